// ==== verilog/angle_pwm_pkg.sv ====
package angle_pwm_pkg;

    // clock and output period timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int BASE_PERIOD_NS = 280000;
    localparam int BAND_PERIOD_NS = 40000;
    localparam int FINE_STEP_NS = 2500;
    localparam int BASE_PERIOD_CYC = BASE_PERIOD_NS / CLK_PERIOD_NS;
    localparam int BAND_PERIOD_CYC = BAND_PERIOD_NS / CLK_PERIOD_NS;
    localparam int FINE_STEP_HALF_CYC = (2 * FINE_STEP_NS) / CLK_PERIOD_NS;

    // widths
    localparam int ANGLE_W = 12;
    localparam int COEFF_W = 12;
    localparam int NUM_COEFF = 32;
    localparam int SEG_W = 5;
    localparam int FRAC_W = 7;
    localparam int PERIOD_W = 20;
    localparam int DUTY_W = 16;
    localparam int NUM_ERR = 12;
    localparam int PIPE_DEPTH = 3;

    // register byte offsets
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] STATUS_OFS = 12'h004;
    localparam logic [11:0] ANGLE_OFS = 12'h008;
    localparam logic [11:0] COEFF_BASE_OFS = 12'h080;
    localparam logic [11:0] COEFF_END_OFS = 12'h0FC;
    localparam logic [12:0] CTRL_RESET = 13'h0000;

    // control field positions
    localparam int CTRL_LIN_EN_BIT = 0;
    localparam int CTRL_SCALE_BIT = 1;
    localparam int CTRL_PEO_BIT = 2;
    localparam int CTRL_PES_BIT = 3;
    localparam int CTRL_BAND_LSB = 4;
    localparam int CTRL_FREQ_LSB = 7;
    localparam int CTRL_UVA_MASK_BIT = 11;
    localparam int CTRL_UVCC_MASK_BIT = 12;

    // duty codes in 1/65536 of a period
    localparam logic [DUTY_W-1:0] DUTY_MIN = 16'h0CCD;
    localparam logic [DUTY_W-1:0] DUTY_SPAN = 16'hE666;
    localparam logic [DUTY_W-1:0] ERR_DUTY [NUM_ERR] = '{
        16'h0CCD, 16'h1B33, 16'h299A, 16'h3800, 16'h4666, 16'h54CD,
        16'h6333, 16'h719A, 16'h8000, 16'h8E66, 16'h9CCD, 16'hAB33};

    // error source bit positions, index equals priority minus one
    localparam int E_WDOG = 0;
    localparam int E_OSC = 1;
    localparam int E_SELF = 2;
    localparam int E_PLL = 3;
    localparam int E_ZCROSS = 4;
    localparam int E_AVG = 5;
    localparam int E_SUPPLY = 6;
    localparam int E_WEAK = 7;
    localparam int E_MEM = 8;
    localparam int E_CLIP = 9;
    localparam int E_STRONG = 10;
    localparam int E_TEMP = 11;

    typedef struct packed {
        logic watchdog_timeout_error;
        logic oscillator_rate_error;
        logic self_check_failure;
        logic pll_locked;
        logic zero_cross_integrity_error;
        logic averaging_fault;
        logic supply_a_low;
        logic supply_cc_low;
        logic field_weak_error;
        logic memory_corrected_error;
        logic front_end_clip_error;
        logic field_strong_error;
        logic temperature_out_of_range;
    } err_in_t;

    typedef struct packed {
        logic uvcc_mask;
        logic uva_mask;
        logic [3:0] pwm_freq;
        logic [2:0] pwm_band;
        logic error_output_style;
        logic error_drives_output;
        logic correction_scale_select;
        logic lin_enable;
    } ctrl_t;

endpackage

// ==== verilog/angle_pwm_out.sv ====
// Operation
// RL1 - watchdog error: priority 1, 5%, latched
// RL2 - oscillator 10.625%; self-check 16.25% latched
// RL3 - loop unlocked: 21.875% until lock reported
// RL4 - zero-cross error: 27.5% while present
// RL5 - averaging fault: 33.125% one period only
// RL6 - supply low: 38.75% while unmasked source
// RL7 - weak field: 44.375% until above threshold
// RL8 - memory corrected: 50% one period only
// RL9 - front-end clip: 55.625% while present
// RL10 - strong field: 61.25% until below threshold
// RL11 - temperature: lowest, 66.875% until in range
// RL12 - band and fine select set frequency
// RL13 - 32 coefficients, one per 11.25 degrees
// RL14 - correction is subtracted from angle
// RL15 - coefficients are 12-bit two's complement
// RL16 - scale bit picks 22.5 or 45 range
// RL17 - interpolate between neighbouring coefficients
// RL18 - bypass keeps identical pipeline latency
// RL19 - disabled correction ignores coefficient storage
// RL20 - duty 5% to 95%, fixed rising edges
// RL21 - errors gated; style 0 tri-states pin
// RL22 - style 1 halves frequency, shows code
// RL23 - last segment interpolates toward first, wraps
// RL24 - lowest priority number wins
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module angle_pwm_out
    import angle_pwm_pkg::*;
#(
    parameter int BASE_CYC = BASE_PERIOD_CYC,
    parameter int BAND_CYC = BAND_PERIOD_CYC
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [ANGLE_W-1:0] angle_in,
    input wire logic angle_valid,
    input wire err_in_t err_in,
    output logic [ANGLE_W-1:0] angle_out,
    output logic angle_out_valid,
    output logic pwm_out,
    output logic pwm_oe
);

    // first active bit, index plus one; zero when none
    function automatic logic [3:0] first_error(input logic [NUM_ERR-1:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = NUM_ERR - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 4'(i + 1);
            end
        end
        return r;
    endfunction

    ctrl_t ctrl;
    logic [COEFF_W-1:0] coeff [NUM_COEFF];
    logic [NUM_ERR-1:0] err_hold;
    logic [NUM_ERR-1:0] err_active;
    logic [3:0] err_index;
    logic period_end;
    logic access;
    logic ctrl_hit;
    logic status_hit;
    logic angle_hit;
    logic coeff_hit;
    logic [4:0] coeff_sel;

    // apb decode, zero wait states
    assign access = psel & penable;
    assign ctrl_hit = (paddr == CTRL_OFS);
    assign status_hit = (paddr == STATUS_OFS);
    assign angle_hit = (paddr == ANGLE_OFS);
    assign coeff_hit = (paddr >= COEFF_BASE_OFS) && (paddr <= COEFF_END_OFS)
        && (paddr[1:0] == 2'b00);
    assign coeff_sel = paddr[6:2];
    assign pready = 1'b1;

    // unmapped or read-only writes answer with an error
    always_comb begin
        pslverr = 1'b0;
        if (access) begin
            if (pwrite) begin
                pslverr = !(ctrl_hit | coeff_hit);
            end else begin
                pslverr = !(ctrl_hit | status_hit | angle_hit | coeff_hit);
            end
        end
    end

    always_comb begin
        prdata = 32'h0000_0000;
        if (ctrl_hit) begin
            prdata = {19'h00000, ctrl};
        end else if (status_hit) begin
            prdata = {14'h0000, pwm_oe, err_index, 1'b0, err_active};
        end else if (angle_hit) begin
            prdata = {20'h00000, angle_out};
        end else if (coeff_hit) begin
            prdata = {{20{coeff[coeff_sel][COEFF_W-1]}}, coeff[coeff_sel]}; // [RL15]
        end
    end

    // control register
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            ctrl <= ctrl_t'(CTRL_RESET);
        end else if (access && pwrite && ctrl_hit) begin
            ctrl <= ctrl_t'(pwdata[12:0]);
        end
    end

    // coefficient storage, kept even while correction is off
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            for (int i = 0; i < NUM_COEFF; i++) begin
                coeff[i] <= '0;
            end
        end else if (access && pwrite && coeff_hit) begin
            coeff[coeff_sel] <= pwdata[COEFF_W-1:0]; // [RL13] [RL15]
        end
    end

    // ---- correction pipeline ----
    logic [PIPE_DEPTH-1:0] pipe_valid;
    logic [ANGLE_W-1:0] s1_angle;
    logic [ANGLE_W-1:0] s2_angle;
    logic [FRAC_W-1:0] s1_frac;
    logic signed [COEFF_W-1:0] s1_c0;
    logic signed [COEFF_W-1:0] s1_c1;
    logic signed [20:0] s2_interp;
    logic signed [COEFF_W:0] c_diff;
    logic signed [20:0] c_step;
    logic signed [21:0] corr;
    logic [21:0] diff;
    logic [SEG_W-1:0] seg;
    logic [SEG_W-1:0] seg_next;

    assign seg = angle_in[ANGLE_W-1:FRAC_W];
    assign seg_next = seg + 5'h01; // [RL23] 31 wraps to 0

    // stage 1: pick the two neighbouring coefficients
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            s1_angle <= '0;
            s1_frac <= '0;
            s1_c0 <= '0;
            s1_c1 <= '0;
        end else begin
            s1_angle <= angle_in;
            s1_frac <= angle_in[FRAC_W-1:0];
            s1_c0 <= coeff[seg]; // [RL13]
            s1_c1 <= coeff[seg_next]; // [RL23]
        end
    end

    assign c_diff = 13'(s1_c1) - 13'(s1_c0);
    assign c_step = 21'(c_diff * $signed({1'b0, s1_frac}));

    // stage 2: interpolation, 7 fraction bits kept
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            s2_angle <= '0;
            s2_interp <= '0;
        end else begin
            s2_angle <= s1_angle;
            s2_interp <= 21'($signed({s1_c0, 7'h00})) + c_step; // [RL17]
        end
    end

    // one coeff lsb is an eighth (or quarter) of an angle lsb
    always_comb begin
        if (!ctrl.lin_enable) begin
            corr = '0; // [RL19]
        end else if (ctrl.correction_scale_select) begin
            corr = {s2_interp, 1'b0}; // [RL16]
        end else begin
            corr = 22'(s2_interp); // [RL16]
        end
    end

    // rounding half lsb; truncation to 12 bits wraps the revolution
    assign diff = {s2_angle, 10'h000} - corr + 22'h000200; // [RL14] [RL23]

    // stage 3: bypass shares this stage, so latency never changes
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            angle_out <= '0;
        end else begin
            angle_out <= diff[21:10]; // [RL18]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            pipe_valid <= '0;
        end else begin
            pipe_valid <= {pipe_valid[PIPE_DEPTH-2:0], angle_valid}; // [RL18]
        end
    end

    assign angle_out_valid = pipe_valid[PIPE_DEPTH-1];

    // ---- error collection ----
    // latched and one-shot sources; a new event beats the clear
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            err_hold <= '0;
        end else begin
            for (int i = 0; i < NUM_ERR; i++) begin
                err_hold[i] <= err_hold[i];
            end
            // cleared as any error-showing period loads, so it shows at most once
            if (period_end && err_view) begin
                err_hold[E_AVG] <= 1'b0; // [RL5]
                err_hold[E_MEM] <= 1'b0; // [RL8]
            end
            if (err_in.watchdog_timeout_error) begin
                err_hold[E_WDOG] <= 1'b1; // [RL1]
            end
            if (err_in.self_check_failure) begin
                err_hold[E_SELF] <= 1'b1; // [RL2]
            end
            if (err_in.averaging_fault) begin
                err_hold[E_AVG] <= 1'b1; // [RL5]
            end
            if (err_in.memory_corrected_error) begin
                err_hold[E_MEM] <= 1'b1; // [RL8]
            end
        end
    end

    // level sources follow their condition directly
    always_comb begin
        err_active = '0;
        err_active[E_WDOG] = err_hold[E_WDOG]; // [RL1]
        err_active[E_OSC] = err_in.oscillator_rate_error; // [RL2]
        err_active[E_SELF] = err_hold[E_SELF]; // [RL2]
        err_active[E_PLL] = !err_in.pll_locked; // [RL3]
        err_active[E_ZCROSS] = err_in.zero_cross_integrity_error; // [RL4]
        err_active[E_AVG] = err_hold[E_AVG]; // [RL5]
        err_active[E_SUPPLY] = (err_in.supply_a_low & !ctrl.uva_mask)
            | (err_in.supply_cc_low & !ctrl.uvcc_mask); // [RL6]
        err_active[E_WEAK] = err_in.field_weak_error; // [RL7]
        err_active[E_MEM] = err_hold[E_MEM]; // [RL8]
        err_active[E_CLIP] = err_in.front_end_clip_error; // [RL9]
        err_active[E_STRONG] = err_in.field_strong_error; // [RL10]
        err_active[E_TEMP] = err_in.temperature_out_of_range; // [RL11]
    end

    assign err_index = first_error(err_active); // [RL24]

    // ---- pwm generator ----
    logic [PERIOD_W-1:0] cnt;
    logic [PERIOD_W-1:0] period_cur;
    logic [PERIOD_W-1:0] high_cur;
    logic [PERIOD_W-1:0] next_period;
    logic [PERIOD_W-1:0] base_period;
    logic [PERIOD_W-1:0] next_high;
    logic [DUTY_W-1:0] next_duty;
    logic [35:0] high_prod;
    logic [27:0] span_prod;
    logic err_view;
    logic next_oe;

    assign period_end = (cnt >= period_cur - 20'h00001);

    // frequency from band (coarse) and fine select
    always_comb begin
        base_period = PERIOD_W'(BASE_CYC)
            + PERIOD_W'(BAND_CYC << ctrl.pwm_band)
            + PERIOD_W'(((FINE_STEP_HALF_CYC << ctrl.pwm_band)
            * int'(ctrl.pwm_freq)) >> 1); // [RL12]
    end

    assign err_view = ctrl.error_drives_output && (err_index != 4'h0); // [RL21]
    assign span_prod = DUTY_SPAN * angle_out;

    // duty code and period for the coming cycle
    always_comb begin
        next_oe = 1'b1;
        next_period = base_period;
        next_duty = DUTY_MIN + span_prod[27:12]; // [RL20]
        if (err_view) begin
            if (ctrl.error_output_style) begin
                next_period = {base_period[PERIOD_W-2:0], 1'b0}; // [RL22]
                next_duty = ERR_DUTY[err_index - 4'h1]; // [RL22] [RL24]
            end else begin
                next_oe = 1'b0; // [RL21]
            end
        end
    end

    assign high_prod = next_period * next_duty;
    assign next_high = high_prod[35:16];

    // counter restarts each period, so rising edges stay fixed
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            cnt <= '0;
            period_cur <= PERIOD_W'(BASE_CYC + BAND_CYC);
            high_cur <= '0;
            pwm_oe <= 1'b0;
        end else if (period_end) begin
            cnt <= '0;
            period_cur <= next_period;
            high_cur <= next_high; // [RL20]
            pwm_oe <= next_oe; // [RL21]
        end else begin
            cnt <= cnt + 20'h00001;
        end
    end

    // falling edge moves with duty; pin low until first period loads
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            pwm_out <= 1'b0;
        end else if (period_end) begin
            pwm_out <= (next_high != '0); // [RL20]
        end else begin
            pwm_out <= (cnt + 20'h00001 < high_cur);
        end
    end

endmodule // angle_pwm_out

`default_nettype wire

// ==== tb/angle_pwm_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module angle_pwm_props
    import angle_pwm_pkg::*;
#(
    parameter int BASE_CYC = 7000,
    parameter int BAND_CYC = 1000
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [ANGLE_W-1:0] angle_in,
    input wire logic angle_valid,
    input wire err_in_t err_in,
    input wire logic [ANGLE_W-1:0] angle_out,
    input wire logic angle_out_valid,
    input wire logic pwm_out,
    input wire logic pwm_oe
);
    logic [12:0] ctl;
    logic wd_seen;
    logic tri_err;
    logic acc;
    int tri_wait;
    // one slowest period, doubled, plus the snapshot edge
    localparam int TRI_LIM = 2 * (BASE_CYC + (BAND_CYC << 7)
        + (((FINE_STEP_HALF_CYC << 7) * 15) >> 1)) + 4;
    assign acc = psel && penable && pready;
    // control shadow, so pin behaviour can be judged from the bus alone
    always_ff @(posedge ref_clk) begin
        if (!resetn) ctl <= '0;
        else if (acc && pwrite && paddr == CTRL_OFS) ctl <= pwdata[12:0];
    end
    // watchdog only clears on reset
    always_ff @(posedge ref_clk) begin
        if (!resetn) wd_seen <= 1'b0;
        else if (err_in.watchdog_timeout_error) wd_seen <= 1'b1;
    end
    // style 0 with a standing error asks for a floating pin
    assign tri_err = ctl[CTRL_PEO_BIT] && !ctl[CTRL_PES_BIT]
        && (wd_seen || err_in.temperature_out_of_range);
    // cycles the pin stays driven while a floating pin is asked for
    always_ff @(posedge ref_clk) begin
        if (!resetn || !tri_err || !pwm_oe) tri_wait <= 0;
        else tri_wait <= tri_wait + 1;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    a_zero_wait: assert property (psel && penable |-> pready)
        else $error("access without ready");
    a_unmapped_err: assert property (acc && paddr == 12'h00C |-> pslverr)
        else $error("unmapped access accepted");
    a_ro_write: assert property (acc && pwrite && paddr == STATUS_OFS |-> pslverr)
        else $error("status write accepted");
    a_ctrl_readback: assert property (acc && !pwrite && paddr == CTRL_OFS
        |-> prdata == {19'h0, ctl}) else $error("control readback differs");
    a_valid_delay: assert property ($past(resetn, 3) |->
        angle_out_valid == $past(angle_valid, 3)) else $error("valid latency off");
    a_bypass_angle: assert property (!ctl[CTRL_LIN_EN_BIT] [*4] |->
        angle_out == $past(angle_in, 3)) else $error("bypass angle differs");
    a_pin_stays_off: assert property ($rose(pwm_oe) |-> !$past(tri_err))
        else $error("pin driven during error");
    a_tri_reached: assert property (tri_wait <= TRI_LIM)
        else $error("pin not released");
    c_tri: cover property ($rose(tri_err));
    c_lin: cover property (ctl[CTRL_LIN_EN_BIT] && angle_out_valid);
    c_rd: cover property (acc && !pwrite && paddr == CTRL_OFS);
endmodule // angle_pwm_props
bind angle_pwm_out angle_pwm_props #(.BASE_CYC(BASE_CYC), .BAND_CYC(BAND_CYC)) props_inst (
    .ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .angle_in(angle_in), .angle_valid(angle_valid), .err_in(err_in), .angle_out(angle_out),
    .angle_out_valid(angle_out_valid), .pwm_out(pwm_out), .pwm_oe(pwm_oe));
`default_nettype wire

// ==== tb/pwm_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module pwm_host_model (
    input wire logic ref_clk,
    input wire logic pwm_out,
    input wire logic pwm_oe,
    output logic [15:0] meas_high,
    output logic [15:0] meas_per,
    output logic meas_stb
);
    logic pin;
    logic last = 1'b0;
    logic [15:0] cnt = '0;
    logic [15:0] hcnt = '0;
    // a floating pin reads low through the line pull-down
    assign pin = pwm_oe ? pwm_out : 1'b0;
    initial begin
        meas_high = '0;
        meas_per = '0;
        meas_stb = 1'b0;
    end
    // rising edges mark period starts, the high time is counted in between
    always @(posedge ref_clk) begin
        last <= pin;
        meas_stb <= 1'b0;
        if (pin && !last) begin
            meas_per <= cnt;
            meas_high <= hcnt;
            meas_stb <= 1'b1;
            cnt <= 16'h0001;
            hcnt <= 16'h0001;
        end else begin
            cnt <= cnt + 16'h0001;
            hcnt <= hcnt + {15'h0, pin};
        end
    end
endmodule // pwm_host_model
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
    $display("wrong value at %0t: %0h vs %0h", $time, (g), (e)); end end
module tb;
    import angle_pwm_pkg::*;
    localparam int BC = 70;
    localparam int DC = 10;
    localparam logic [11:0] TA [4] = '{12'h000, 12'h040, 12'hFC0, 12'hFFF};
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [11:0] angle_in = '0;
    logic angle_valid = 1'b0;
    logic [11:0] ev = '0;
    logic [31:0] prdata;
    logic pready, pslverr, angle_out_valid, pwm_out, pwm_oe, ms;
    logic [11:0] angle_out, a, ea;
    logic [15:0] mh, mp;
    logic [33:0] r;
    logic [31:0] ep;
    logic [33:0] rq [$];
    logic [11:0] aq [$];
    logic [31:0] pq [$];
    err_in_t err_in;
    ctrl_t c = '0;
    int num_errors = 0;
    int n_compared = 0;
    int cf [32];
    int w;
    // lock lost is the absence of the locked flag; second supply stays quiet
    assign err_in = {ev[0], ev[1], ev[2], ~ev[3], ev[4], ev[5], ev[6], 1'b0, ev[7:0] == 0 ?
        ev[7] : ev[7], ev[8], ev[9], ev[10], ev[11]};
    always #20 ref_clk = ~ref_clk;
    angle_pwm_out #(.BASE_CYC(BC), .BAND_CYC(DC)) angle_pwm_out_inst (
        .ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .angle_in(angle_in), .angle_valid(angle_valid), .err_in(err_in), .angle_out(angle_out),
        .angle_out_valid(angle_out_valid), .pwm_out(pwm_out), .pwm_oe(pwm_oe));
    pwm_host_model pwm_host_model_inst (.ref_clk(ref_clk), .pwm_out(pwm_out), .pwm_oe(pwm_oe),
        .meas_high(mh), .meas_per(mp), .meas_stb(ms));
    task automatic finish_test();
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic tmo();
        num_errors++;
        $display("wrong value at %0t: no answer in time", $time);
        finish_test();
    endtask
    task automatic do_reset();
        resetn <= 1'b0;
        ev <= '0;
        repeat (12) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
    endtask
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d,
        input logic [32:0] ex);
        int k;
        k = 0;
        rq.push_back({w, ex});
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) tmo();
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    // skip the period in flight, then judge the next whole one
    task automatic pwm_exp(input int h, input int p);
        int k;
        k = 0;
        repeat (6) @(posedge ref_clk);
        do begin
            @(posedge ref_clk);
            #1;
            k++;
        end while (ms !== 1'b1 && k < 9000);
        @(posedge ref_clk);
        #1;
        pq.push_back({h[15:0], p[15:0]});
        while (pq.size() > 0 && k < 12000) begin
            @(posedge ref_clk);
            k++;
        end
        if (pq.size() > 0) tmo();
    endtask
    function automatic logic [11:0] exp_ang(input logic [11:0] x, input logic en, input logic ls);
        int s, i, o;
        s = x[11:7];
        i = cf[s] * 128 + (cf[(s + 1) % 32] - cf[s]) * int'(x[6:0]);
        if (!en) i = 0;
        o = (int'(x) * 1024 - i * (ls ? 2 : 1) + 512) >>> 10;
        return o[11:0];
    endfunction
    function automatic int dty(input logic [11:0] x, input int per);
        return (per * (int'(DUTY_MIN) + ((int'(DUTY_SPAN) * int'(x)) >> 12))) >> 16;
    endfunction
    function automatic int eh(input int p);
        return (2 * (BC + DC) * int'(ERR_DUTY[p])) >> 16;
    endfunction
    // monitors take the oldest note whenever a result shows up
    always @(posedge ref_clk) begin
        if (psel && penable && pready === 1'b1 && rq.size() > 0) begin
            r = rq.pop_front();
            `CHK(pslverr, r[32])
            if (!r[33]) `CHK(prdata, r[31:0])
        end
        if (angle_out_valid === 1'b1) begin
            ea = aq.size() > 0 ? aq.pop_front() : 12'hXXX;
            `CHK(angle_out, ea)
        end
        if (ms === 1'b1 && pq.size() > 0) begin
            ep = pq.pop_front();
            `CHK(mh, ep[31:16])
            `CHK(mp, ep[15:0])
        end
    end
    initial begin
        void'($urandom(32'h1833));
        do_reset();
        // extremes sit either side of the wrap seam
        for (int i = 0; i < 32; i++) begin
            cf[i] = (i == 0) ? -2048 : (i == 31) ? 2047 : int'($urandom_range(4095)) - 2048;
            apb(1'b1, 12'(COEFF_BASE_OFS + 4 * i), 32'(cf[i]), '0);
        end
        apb(1'b0, COEFF_BASE_OFS, '0, {1'b0, 32'hFFFFF800});
        apb(1'b0, 12'h00C, '0, {1'b1, 32'h0});
        apb(1'b1, STATUS_OFS, 32'h1, {1'b1, 32'h0});
        for (int m = 0; m < 3; m++) begin
            c.lin_enable = (m > 0);
            c.correction_scale_select = (m == 2);
            apb(1'b1, CTRL_OFS, 32'(c), '0);
            apb(1'b0, CTRL_OFS, '0, {1'b0, 32'(c)});
            for (int j = 0; j < 40; j++) begin
                a = (j < 4) ? TA[j] : 12'($urandom);
                angle_in <= a;
                angle_valid <= 1'b1;
                aq.push_back(exp_ang(a, c.lin_enable, c.correction_scale_select));
                @(posedge ref_clk);
            end
            angle_valid <= 1'b0;
            repeat (5) @(posedge ref_clk);
        end
        c = '0;
        angle_in <= 12'h800;
        for (int b = 0; b < 4; b++) begin
            c.pwm_band = 3'(b);
            apb(1'b1, CTRL_OFS, 32'(c), '0);
            pwm_exp(dty(12'h800, BC + (DC << b)), BC + (DC << b));
        end
        c.pwm_band = 3'h0;
        apb(1'b1, CTRL_OFS, 32'(c), '0);
        ev[11] <= 1'b1;
        foreach (TA[k]) begin
            angle_in <= TA[k];
            pwm_exp(dty(TA[k], BC + DC), BC + DC);
        end
        c.error_drives_output = 1'b1;
        c.error_output_style = 1'b1;
        apb(1'b1, CTRL_OFS, 32'(c), '0);
        // raise one source after another, each outranking all still standing
        for (int p = 11; p >= 0; p--) begin
            // one-shots start just after a period begins, so the shown period is known
            if (p == 5 || p == 8) begin
                w = 0;
                do begin
                    @(posedge ref_clk);
                    #1;
                    w++;
                end while (ms !== 1'b1 && w < 9000);
                if (w >= 9000) tmo();
                @(posedge ref_clk);
            end
            ev[p] <= 1'b1;
            if (p == 0 || p == 2 || p == 5 || p == 8) begin
                @(posedge ref_clk);
                ev[p] <= 1'b0;
            end
            pwm_exp(eh(p), 2 * (BC + DC));
            if (p == 5 || p == 8) pwm_exp(eh(p + 1), 2 * (BC + DC));
        end
        c.error_output_style = 1'b0;
        apb(1'b1, CTRL_OFS, 32'(c), '0);
        repeat (400) @(posedge ref_clk);
        `CHK(pwm_oe, 1'b0)
        do_reset();
        finish_test();
    end
endmodule // tb
`default_nettype wire
